/* hw/tcu8_consts.vh */
// constants for the 8-bit timer counter compare unit
`ifndef TCU8_CONSTS_VH
`define TCU8_CONSTS_VH
// register word offsets (byte address = 4 * index)
`define TCU8_IDX_CTRL 4'h0
`define TCU8_IDX_COUNT 4'h1
`define TCU8_IDX_CMP 4'h2
`define TCU8_IDX_FLAGS 4'h3
`define TCU8_IDX_MASK 4'h4
`define TCU8_IDX_PORT 4'h5
`define TCU8_IDX_PRESC 4'h6
// control register fields
`define TCU8_CS_LO 0
`define TCU8_CS_HI 2
`define TCU8_WGM_LOW_BIT 3
`define TCU8_WGM_HIGH_BIT 4
`define TCU8_COM_LO 5
`define TCU8_COM_HI 6
`define TCU8_FOC_BIT 7
// flag and mask bits
`define TCU8_OVF_BIT 0
`define TCU8_CMF_BIT 1
`define TCU8_GIE_BIT 2
// port bits
`define TCU8_PORT_DATA_BIT 0
`define TCU8_PORT_DIR_BIT 1
// waveform modes
`define TCU8_WGM_NORMAL 2'h0
`define TCU8_WGM_PC_PWM 2'h1
`define TCU8_WGM_CTC 2'h2
`define TCU8_WGM_FAST_PWM 2'h3
// clock source selections
`define TCU8_CS_STOP 3'h0
`define TCU8_CS_DIV1 3'h1
`define TCU8_CS_DIV8 3'h2
`define TCU8_CS_DIV64 3'h3
`define TCU8_CS_DIV256 3'h4
`define TCU8_CS_DIV1024 3'h5
`define TCU8_CS_EXT_FALL 3'h6
`define TCU8_CS_EXT_RISE 3'h7
// count values
`define TCU8_BOTTOM 8'h00
`define TCU8_MAX 8'hff
`define TCU8_PRESC_W 10
`endif

/* hw/tcu8_top.v */
// 8-bit timer counter with single compare unit and avalon-mm register slave
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "tcu8_consts.vh"
module tcu8_top (
    // clock, reset, enable
    input wire clock,
    input wire rst_n,
    input wire clk_en,
    // avalon-mm slave
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // external timer input pin
    input wire ext_tick_pin,
    // interrupt service acknowledge from cpu
    input wire cmp_irq_ack,
    input wire ovf_irq_ack,
    // interrupt requests
    output reg cmp_irq,
    output reg ovf_irq,
    // compare output pin
    output reg compare_output_pin,
    output reg compare_output_oe
);

////////////////////////////////////////////////////////////////////////////////
function is_pwm;
    input [1:0] m;
    begin
        is_pwm = (m == `TCU8_WGM_PC_PWM) || (m == `TCU8_WGM_FAST_PWM);
    end
endfunction

// write strobe for one register index
function wr_to;
    input en;
    input [3:0] a;
    input [3:0] idx;
    begin
        wr_to = en && (a == idx);
    end
endfunction

// compare output state that a real or forced match applies
function oc_next;
    input [1:0] com;
    input pwm_m;
    input q;
    input down;
    begin
        case (com)
            2'h1: oc_next = pwm_m ? q : !q;
            2'h2: oc_next = pwm_m ? down : 1'b0;
            2'h3: oc_next = pwm_m ? !down : 1'b1;
            default: oc_next = q;
        endcase
    end
endfunction

reg [2:0] clock_source_select;
reg waveform_mode_low;
reg waveform_mode_high;
reg [1:0] compare_output_mode;
reg [7:0] count_value;
reg [7:0] compare_register;
reg [7:0] compare_buffer;
reg overflow_flag;
reg compare_match_flag;
reg compare_irq_enable;
reg overflow_irq_enable;
reg global_irq_enable;
reg port_data;
reg port_dir;
reg compare_output_q;
reg dir_down_q;
reg block_q;
reg [9:0] presc_q;
reg ext_s1_q;
reg ext_s2_q;
reg ext_prev_q;
reg pending_match_q;
reg [1:0] resp_q;

wire [1:0] waveform_mode_bits = {waveform_mode_high, waveform_mode_low};
wire pwm = is_pwm(waveform_mode_bits);
wire [7:0] cmp_eff = compare_register;
wire is_max = (count_value == `TCU8_MAX);
wire is_bottom = (count_value == `TCU8_BOTTOM);
wire match = (count_value == cmp_eff);
// request taken on an idle edge; a write lands on the edge that shows waitrequest low
wire acc = (avs_read || avs_write) && resp_q == 2'h0;
wire wr = avs_write && resp_q == 2'h1 && avs_byteenable[0];
wire wr_count = wr_to(wr, avs_address, `TCU8_IDX_COUNT);
wire wr_ctrl = wr_to(wr, avs_address, `TCU8_IDX_CTRL);
wire wr_cmp = wr_to(wr, avs_address, `TCU8_IDX_CMP);
wire wr_flags = wr_to(wr, avs_address, `TCU8_IDX_FLAGS);
wire wr_mask = wr_to(wr, avs_address, `TCU8_IDX_MASK);
wire wr_port = wr_to(wr, avs_address, `TCU8_IDX_PORT);

////////////////////////////////////////////////////////////////////////////////
// tick generation
reg tick;
always @* begin
    case (clock_source_select)
        `TCU8_CS_STOP: tick = 1'b0;
        `TCU8_CS_DIV1: tick = 1'b1;
        `TCU8_CS_DIV8: tick = (presc_q[2:0] == 3'h7);
        `TCU8_CS_DIV64: tick = (presc_q[5:0] == 6'h3f);
        `TCU8_CS_DIV256: tick = (presc_q[7:0] == 8'hff);
        `TCU8_CS_DIV1024: tick = (presc_q == 10'h3ff);
        `TCU8_CS_EXT_FALL: tick = ext_prev_q && !ext_s2_q;
        `TCU8_CS_EXT_RISE: tick = !ext_prev_q && ext_s2_q;
        default: tick = 1'b0;
    endcase
end

always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        presc_q <= 10'h000;
    end else if (clk_en) begin
        presc_q <= presc_q + 10'h001;
    end
end

// external pin: two sync stages, then an edge history stage
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        ext_s1_q <= 1'b0;
        ext_s2_q <= 1'b0;
        ext_prev_q <= 1'b0;
    end else if (clk_en) begin
        ext_s1_q <= ext_tick_pin;
        ext_s2_q <= ext_s1_q;
        ext_prev_q <= ext_s2_q;
    end
end

////////////////////////////////////////////////////////////////////////////////
// count engine and compare unit
reg [7:0] count_d;
reg dir_down_d;
reg ovf_set;
always @* begin
    count_d = count_value;
    dir_down_d = dir_down_q;
    ovf_set = 1'b0;
    case (waveform_mode_bits)
        `TCU8_WGM_NORMAL: begin
            count_d = count_value + 8'h01;
            ovf_set = is_max;
        end
        `TCU8_WGM_CTC: begin
            count_d = match ? `TCU8_BOTTOM : count_value + 8'h01;
            ovf_set = is_max;
        end
        `TCU8_WGM_FAST_PWM: begin
            count_d = count_value + 8'h01;
            ovf_set = is_max;
        end
        `TCU8_WGM_PC_PWM: begin
            if (is_max)
                dir_down_d = 1'b1;
            else if (is_bottom)
                dir_down_d = 1'b0;
            count_d = dir_down_d ? count_value - 8'h01 : count_value + 8'h01;
            ovf_set = is_bottom && dir_down_q;
        end
        default: count_d = count_value;
    endcase
end

// waveform generator next output; a force uses the mode bits written with it
wire oc_match_d = oc_next(compare_output_mode, pwm, compare_output_q, dir_down_q);
wire oc_force_d = oc_next(avs_writedata[`TCU8_COM_HI:`TCU8_COM_LO], 1'b0, compare_output_q, dir_down_q);

wire buf_load = pwm && ((waveform_mode_bits == `TCU8_WGM_FAST_PWM) ? is_max : is_max || is_bottom);
wire force_cmp = wr_ctrl && avs_writedata[`TCU8_FOC_BIT] && !pwm;
// a count write now or before this tick hides the match
wire match_ok = match && !block_q && !wr_count;

// counter value and direction
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        count_value <= `TCU8_BOTTOM;
        dir_down_q <= 1'b0;
    end else if (clk_en) begin
        if (wr_count) begin
            count_value <= avs_writedata[7:0];
        end else if (tick) begin
            count_value <= count_d;
            dir_down_q <= dir_down_d;
        end
    end
end

// match blocking window after a count write
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        block_q <= 1'b0;
    end else if (clk_en) begin
        if (wr_count)
            block_q <= 1'b1;
        else if (tick)
            block_q <= 1'b0;
    end
end

// compare register and its buffer
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        compare_register <= 8'h00;
        compare_buffer <= 8'h00;
    end else if (clk_en) begin
        if (wr_cmp && !pwm)
            compare_register <= avs_writedata[7:0];
        else if (tick && buf_load)
            compare_register <= compare_buffer;
        if (wr_cmp)
            compare_buffer <= avs_writedata[7:0];
    end
end

// flags: a match becomes the flag on the following tick, set beats clear
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        pending_match_q <= 1'b0;
        compare_match_flag <= 1'b0;
        overflow_flag <= 1'b0;
    end else if (clk_en) begin
        if (tick)
            pending_match_q <= match_ok;
        if (tick && pending_match_q)
            compare_match_flag <= 1'b1;
        else if ((wr_flags && avs_writedata[`TCU8_CMF_BIT]) || (cmp_irq_ack && cmp_irq))
            compare_match_flag <= 1'b0;
        if (tick && ovf_set && !wr_count)
            overflow_flag <= 1'b1;
        else if ((wr_flags && avs_writedata[`TCU8_OVF_BIT]) || (ovf_irq_ack && ovf_irq))
            overflow_flag <= 1'b0;
    end
end

// compare output register, kept across mode changes
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        compare_output_q <= 1'b0;
    end else if (clk_en) begin
        if (force_cmp)
            compare_output_q <= oc_force_d;
        else if (tick && match_ok)
            compare_output_q <= oc_match_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// register slave
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        clock_source_select <= `TCU8_CS_STOP;
        waveform_mode_low <= 1'b0;
        waveform_mode_high <= 1'b0;
        compare_output_mode <= 2'h0;
        compare_irq_enable <= 1'b0;
        overflow_irq_enable <= 1'b0;
        global_irq_enable <= 1'b0;
        port_data <= 1'b0;
        port_dir <= 1'b0;
        resp_q <= 2'h0;
        avs_waitrequest <= 1'b1;
        avs_readdata <= 32'h00000000;
    end else if (clk_en) begin
        if (wr_ctrl) begin
            clock_source_select <= avs_writedata[`TCU8_CS_HI:`TCU8_CS_LO];
            waveform_mode_low <= avs_writedata[`TCU8_WGM_LOW_BIT];
            waveform_mode_high <= avs_writedata[`TCU8_WGM_HIGH_BIT];
            compare_output_mode <= avs_writedata[`TCU8_COM_HI:`TCU8_COM_LO];
        end
        if (wr_mask) begin
            overflow_irq_enable <= avs_writedata[`TCU8_OVF_BIT];
            compare_irq_enable <= avs_writedata[`TCU8_CMF_BIT];
            global_irq_enable <= avs_writedata[`TCU8_GIE_BIT];
        end
        if (wr_port) begin
            port_data <= avs_writedata[`TCU8_PORT_DATA_BIT];
            port_dir <= avs_writedata[`TCU8_PORT_DIR_BIT];
        end
        // one wait cycle: accept, then release waitrequest for one cycle
        if (acc) begin
            resp_q <= 2'h1;
            avs_waitrequest <= 1'b0;
            avs_readdata <= 32'h00000000;
            case (avs_address)
                `TCU8_IDX_CTRL: avs_readdata[7:0] <= {1'b0, compare_output_mode, waveform_mode_high,
                    waveform_mode_low, clock_source_select};
                `TCU8_IDX_COUNT: avs_readdata[7:0] <= count_value;
                `TCU8_IDX_CMP: avs_readdata[7:0] <= pwm ? compare_buffer : compare_register;
                `TCU8_IDX_FLAGS: avs_readdata[1:0] <= {compare_match_flag, overflow_flag};
                `TCU8_IDX_MASK: avs_readdata[2:0] <= {global_irq_enable, compare_irq_enable,
                    overflow_irq_enable};
                `TCU8_IDX_PORT: avs_readdata[2:0] <= {compare_output_q, port_dir, port_data};
                default: avs_readdata <= 32'h00000000;
            endcase
        end else if (resp_q == 2'h1) begin
            resp_q <= 2'h0;
            avs_waitrequest <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt requests and pin drive
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        cmp_irq <= 1'b0;
        ovf_irq <= 1'b0;
    end else if (clk_en) begin
        cmp_irq <= compare_match_flag && compare_irq_enable && global_irq_enable;
        ovf_irq <= overflow_flag && overflow_irq_enable && global_irq_enable;
    end
end

// pin source: compare output takes over once its mode bits are nonzero
always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
        compare_output_pin <= 1'b0;
        compare_output_oe <= 1'b0;
    end else if (clk_en) begin
        compare_output_pin <= (compare_output_mode != 2'h0) ? compare_output_q : port_data;
        compare_output_oe <= port_dir;
    end
end

endmodule
`default_nettype wire

/* verif/tcu8_chk.sv */
// assertion checker for the timer counter compare unit ports
`timescale 1ns/1ps
`default_nettype none
module tcu8_chk (
    // clock and reset
    input wire clock,
    input wire rst_n,
    input wire clk_en,
    // register bus
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // interrupts and pin
    input wire cmp_irq_ack,
    input wire ovf_irq_ack,
    input wire cmp_irq,
    input wire ovf_irq,
    input wire compare_output_pin,
    input wire compare_output_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest && clk_en;
    endsequence
    sequence s_pulse;
        ##[1:8] !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    AST_ANSWER: assert property (s_req |-> s_pulse) else $error("bus request not answered");
    AST_WAIT_PULSE: assert property (!avs_waitrequest && clk_en |=> avs_waitrequest) else $error("long answer");
    AST_TAKE: assert property ($fell(avs_waitrequest) |-> $past(avs_read) || $past(avs_write)) else $error("no request");
    AST_RD_UPPER: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0) else $error("upper bits set");
    AST_RD_HOLD: assert property (avs_waitrequest |-> $stable(avs_readdata)) else $error("read data moved");
    AST_RST_OUT: assert property ($rose(rst_n) |-> !compare_output_pin && !compare_output_oe && !cmp_irq && !ovf_irq)
        else $error("outputs not cleared by reset");
    AST_CMP_ACK: assert property (cmp_irq && cmp_irq_ack |-> ##[1:3] !cmp_irq) else $error("cmp irq kept");
    AST_OVF_ACK: assert property (ovf_irq && ovf_irq_ack |-> ##[1:3] !ovf_irq) else $error("ovf irq kept");
    AST_CMP_FALL: assert property ($fell(cmp_irq) |-> $past(cmp_irq_ack, 2) || $past(cmp_irq_ack, 3)
        || $past(avs_write, 2) || $past(avs_write, 3) || $past(cmp_irq_ack)) else $error("cmp irq dropped");
endmodule
bind tcu8_top tcu8_chk i_tcu8_chk (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cmp_irq_ack(cmp_irq_ack), .ovf_irq_ack(ovf_irq_ack), .cmp_irq(cmp_irq), .ovf_irq(ovf_irq),
    .compare_output_pin(compare_output_pin), .compare_output_oe(compare_output_oe));
`default_nettype wire

/* verif/tcu8_cpu_model.sv */
// cpu and pin side model: services interrupts, drives the external tick pin
`timescale 1ns/1ps
`default_nettype none
module tcu8_cpu_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // bench controls
    input wire logic en_ack,
    input wire logic en_ext,
    // device side
    input wire logic cmp_irq,
    input wire logic ovf_irq,
    output logic cmp_irq_ack,
    output logic ovf_irq_ack,
    output logic ext_tick_pin
);
    logic [1:0] div_q = 2'h0;
    logic pick;
    initial begin
        cmp_irq_ack = 1'b0;
        ovf_irq_ack = 1'b0;
        ext_tick_pin = 1'b0;
    end
    // pin idles low, one edge pair every eight cycles
    always @(posedge clock) begin
        div_q <= div_q + 2'h1;
        if (div_q == 2'h3) ext_tick_pin <= en_ext & ~ext_tick_pin;
    end
    // service after a random latency, then hold off
    always begin
        @(posedge clock);
        if (rst_n && en_ack && (cmp_irq || ovf_irq)) begin
            pick = cmp_irq;
            repeat ($urandom % 4) @(posedge clock);
            cmp_irq_ack <= pick;
            ovf_irq_ack <= !pick;
            @(posedge clock);
            cmp_irq_ack <= 1'b0;
            ovf_irq_ack <= 1'b0;
            repeat (4) @(posedge clock);
        end
    end
endmodule
`default_nettype wire

/* verif/timer8_counter_compare_unit_tb.sv */
// self-checking bench for the timer counter compare unit
`timescale 1ns/1ps
`default_nettype none
module timer8_counter_compare_unit_tb;
    localparam logic [3:0] A_CT = 4'h0, A_CN = 4'h1, A_CM = 4'h2, A_FL = 4'h3, A_MK = 4'h4, A_PT = 4'h5;
    logic clock = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, en_ack = 1'b0, en_ext = 1'b0;
    logic seen_cmp = 1'b0, seen_ovf = 1'b0, clk_en = 1'b1;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0, rd;
    logic [7:0] v, c;
    wire avs_waitrequest, cmp_irq, ovf_irq, cmp_irq_ack, ovf_irq_ack, ext_tick_pin, compare_output_pin, compare_output_oe;
    wire [31:0] avs_readdata;
    integer num_errors = 0, n_checks = 0, i, j;
    always #20 clock = ~clock;
    always @(posedge clock) begin
        if (cmp_irq === 1'b1) seen_cmp <= 1'b1;
        if (ovf_irq === 1'b1) seen_ovf <= 1'b1;
    end
    tcu8_top i_tcu8_top (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_tick_pin(ext_tick_pin),
        .cmp_irq_ack(cmp_irq_ack), .ovf_irq_ack(ovf_irq_ack), .cmp_irq(cmp_irq), .ovf_irq(ovf_irq),
        .compare_output_pin(compare_output_pin), .compare_output_oe(compare_output_oe));
    tcu8_cpu_model i_tcu8_cpu_model (.clock(clock), .rst_n(rst_n), .en_ack(en_ack), .en_ext(en_ext),
        .cmp_irq(cmp_irq), .ovf_irq(ovf_irq), .cmp_irq_ack(cmp_irq_ack), .ovf_irq_ack(ovf_irq_ack),
        .ext_tick_pin(ext_tick_pin));
    ////////////////////////////////////////////////////////////////
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", n_checks, num_errors);
            if (num_errors == 0 && n_checks > 0) begin
                $display("TEST PASSED");
            end else begin
                $display("TEST FAILED");
            end
            $finish;
        end
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        begin
            n_checks++;
            if (seen !== exp) begin
                num_errors++;
                $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // hold the request until waitrequest is sampled low
    task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        integer k;
        begin
            avs_address <= a;
            avs_read <= !w;
            avs_write <= w;
            avs_writedata <= {24'h0, d};
            k = 0;
            do begin
                @(posedge clock);
                k++;
            end while (avs_waitrequest !== 1'b0 && k < 60);
            if (avs_waitrequest !== 1'b0) begin
                chk("bus answer", 1, 0);
                report_and_stop;
            end
            rd = avs_readdata;
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            @(posedge clock);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task rdchk(input string nm, input logic [3:0] a, input logic [31:0] exp);
        begin
            bus(1'b0, a, 8'h0);
            chk(nm, rd, exp);
        end
    endtask
    function automatic integer divf(input integer cs);
        case (cs)
            1: divf = 1;
            3: divf = 64;
            4: divf = 256;
            5: divf = 1024;
            default: divf = 8;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h59b3ec3e));
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        chk("pin reset", {compare_output_oe, compare_output_pin}, 0);
        rdchk("ctrl reset", A_CT, 0);
        rdchk("port reset", A_PT, 0);
        for (i = 6; i < 16; i = i + 9) rdchk("unmapped", i[3:0], 0);
        $display("test reset done");
        v = $urandom;
        wr(A_CN, v);
        repeat (20) @(posedge clock);
        rdchk("count stopped", A_CN, {24'h0, v});
        avs_byteenable <= 4'h0;
        wr(A_CN, ~v);
        avs_byteenable <= 4'hf;
        rdchk("count no lane", A_CN, {24'h0, v});
        wr(A_CT, 8'ha0);
        rdchk("port forced", A_PT, 32'h4);
        rdchk("flags forced", A_FL, 0);
        rdchk("count forced", A_CN, {24'h0, v});
        rdchk("ctrl fields", A_CT, 32'h20);
        chk("oe dir in", compare_output_oe, 0);
        wr(A_PT, 8'h02);
        repeat (2) @(posedge clock);
        chk("pin driven", {compare_output_oe, compare_output_pin}, 2'b11);
        wr(A_CT, 8'h38);
        rdchk("port mode kept", A_PT, 32'h6);
        wr(A_CT, 8'h18);
        repeat (2) @(posedge clock);
        chk("pin from port", {compare_output_oe, compare_output_pin}, 2'b10);
        wr(A_PT, 8'h00);
        $display("test force done");
        wr(A_CT, 8'h08);
        wr(A_CN, 8'hf0);
        wr(A_CT, 8'h09);
        repeat (30) @(posedge clock);
        wr(A_CT, 8'h00);
        bus(1'b0, A_CN, 8'h0);
        chk("down count", rd > 32'hd0 && rd < 32'hf0, 1);
        wr(A_FL, 8'h03);
        wr(A_CN, 8'hfc);
        wr(A_CT, 8'h01);
        repeat (20) @(posedge clock);
        wr(A_CT, 8'h00);
        bus(1'b0, A_CN, 8'h0);
        chk("wrap", rd < 32'h20, 1);
        bus(1'b0, A_FL, 8'h0);
        chk("ovf flag", rd[0], 1);
        en_ack <= 1'b1;
        wr(A_MK, 8'h05);
        repeat (20) @(posedge clock);
        chk("ovf irq", {seen_ovf, ovf_irq}, 2'b10);
        rdchk("flags serviced", A_FL, 32'h2);
        wr(A_FL, 8'h02);
        rdchk("flags w1c", A_FL, 0);
        wr(A_MK, 8'h00);
        en_ack <= 1'b0;
        $display("test overflow done");
        c = 8'h20 + 8'($urandom % 192);
        wr(A_CM, c);
        wr(A_CN, c - 8'h10);
        wr(A_MK, 8'h02);
        wr(A_CT, 8'h01);
        repeat (40) @(posedge clock);
        chk("irq no global", seen_cmp, 0);
        bus(1'b0, A_FL, 8'h0);
        chk("cmp flag", rd[1], 1);
        en_ack <= 1'b1;
        wr(A_MK, 8'h06);
        repeat (20) @(posedge clock);
        chk("cmp irq", {seen_cmp, cmp_irq}, 2'b10);
        bus(1'b0, A_FL, 8'h0);
        chk("cmp serviced", rd[1], 0);
        wr(A_CT, 8'h00);
        wr(A_MK, 8'h00);
        en_ack <= 1'b0;
        for (j = 0; j < 2; j++) begin
            wr(A_FL, 8'h03);
            wr(A_CM, 8'h50);
            wr(A_CN, 8'h50 - 8'(4 * j));
            wr(A_CT, 8'h01);
            repeat (10) @(posedge clock);
            wr(A_CT, 8'h00);
            bus(1'b0, A_FL, 8'h0);
            chk("blocked match", rd[1], j[0]);
        end
        $display("test compare done");
        wr(A_CM, 8'h10);
        wr(A_CN, 8'h00);
        wr(A_CT, 8'h11);
        for (j = 0; j < 12; j++) begin
            repeat ($urandom % 8) @(posedge clock);
            bus(1'b0, A_CN, 8'h0);
            chk("ctc top", rd <= 32'h10, 1);
        end
        for (j = 0; j < 2; j++) begin
            wr(A_CT, 8'h00);
            wr(A_CN, 8'h00);
            wr(A_CT, 8'h01);
            repeat (5) @(posedge clock);
            clk_en <= !j[0];
            repeat (25) @(posedge clock);
            clk_en <= 1'b1;
            wr(A_CT, 8'h00);
            bus(1'b0, A_CN, 8'h0);
            if (j == 0) v = rd[7:0];
            else chk("frozen count", rd, {24'h0, v - 8'd25});
        end
        en_ext <= 1'b1;
        for (j = 1; j < 8; j++) begin
            wr(A_CT, 8'h00);
            wr(A_CN, 8'h00);
            wr(A_CT, j[7:0]);
            repeat (64) @(posedge clock);
            wr(A_CT, 8'h00);
            bus(1'b0, A_CN, 8'h0);
            chk("tick rate", rd <= 70 / divf(j) + 1, 1);
            if (j < 3 || j > 5) chk("tick runs", rd != 0, 1);
        end
        $display("test modes done");
        report_and_stop;
    end
endmodule
`default_nettype wire
